// *** hw/adm_cfg.svh ***
// offsets, field positions and timing counts of the sampling bus master
`ifndef ADM_CFG_SVH
`define ADM_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ADM_REG_CTRL    8'h00
`define ADM_REG_CHAN    8'h04
`define ADM_REG_DIV1    8'h08
`define ADM_REG_DIV2    8'h0C
`define ADM_REG_ADDR    8'h10
`define ADM_REG_COUNT   8'h14
`define ADM_REG_REMAIN  8'h18
`define ADM_REG_XFER    8'h1C
`define ADM_REG_STAT    8'h20
`define ADM_REG_MASK    8'h24
`define ADM_REG_OVR     8'h28
// ----------------------------------------
// control fields (mode in bits 2:0)
// ----------------------------------------
`define ADM_CTRL_SCAN   3
`define ADM_CTRL_START  4
`define ADM_CTRL_STOP   5
`define ADM_CTRL_CONT   6
`define ADM_CTRL_DRAIN  7
// ----------------------------------------
// conversion modes and status bits
// ----------------------------------------
`define ADM_MODE_TMR_INT 3'h1
`define ADM_MODE_TMR_DMA 3'h2
`define ADM_MODE_EXT_POL 3'h3
`define ADM_MODE_EXT_INT 3'h4
`define ADM_MODE_EXT_DMA 3'h5
`define ADM_ST_DONE     0
`define ADM_ST_HALF     1
`define ADM_ST_OVR      2
// ----------------------------------------
// timing: 10 MHz core clock, 2 MHz pacer base
// ----------------------------------------
`define ADM_CLK_NS      100
`define ADM_PACER_NS    500
`define ADM_BASE_DIV    (`ADM_PACER_NS / `ADM_CLK_NS)
`define ADM_FIFO_DEPTH  16
`endif

// *** hw/adm_pkg.sv ***
// types of the sampling bus master
`default_nettype none
package adm_pkg;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_REQ  = 2'b01,
		BUS_XFER = 2'b10
	} adm_bus_t;
endpackage
`default_nettype wire

// *** hw/adm_dma.sv ***
// paced sample acquisition with longword bus-master writes and AXI4-Lite registers
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "adm_cfg.svh"
module adm_dma (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             busReq,
	input  wire logic        busGnt,
	output logic             wrValid,
	output logic [31:0]      wrAddr,
	output logic [31:0]      wrData,
	input  wire logic        wrReady,
	output logic             adcStart,
	output logic [3:0]       adcChan,
	input  wire logic        adcDone,
	input  wire logic [11:0] adcData,
	input  wire logic        extTrig,
	output logic             irq
);
	// ----------------------------------------
	// mode decoding
	// ----------------------------------------
	function automatic logic isDmaMode(input logic [2:0] m);
		isDmaMode = (m == `ADM_MODE_TMR_DMA) || (m == `ADM_MODE_EXT_DMA);
	endfunction
	function automatic logic isTmrMode(input logic [2:0] m);
		isTmrMode = (m == `ADM_MODE_TMR_INT) || (m == `ADM_MODE_TMR_DMA);
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [2:0]  mode, next_mode;
	logic        autoScan, next_autoScan, contMode, next_contMode, running, next_running;
	logic [3:0]  startChan, next_startChan, next_adcChan;
	logic [15:0] div1, next_div1, div2, next_div2, cnt1, next_cnt1, cnt2, next_cnt2;
	logic [31:0] dstAddr, next_dstAddr, curAddr, next_curAddr, xferCnt, next_xferCnt;
	logic [26:0] byteCount, next_byteCount, remain, next_remain, convBytes, next_convBytes;
	logic [2:0]  stat, next_stat, mask, next_mask, baseCnt, next_baseCnt;
	logic [15:0] ovrCnt, next_ovrCnt;
	logic        halfPend, next_halfPend, adcBusy, next_adcBusy;
	logic [15:0] mem [0:`ADM_FIFO_DEPTH-1];
	logic [3:0]  wPtr, next_wPtr, rPtr, next_rPtr;
	logic [4:0]  fCnt, next_fCnt;
	adm_pkg::adm_bus_t busSt, next_busSt;
	logic        awHeld, next_awHeld, wHeld, next_wHeld;
	logic [7:0]  awA, next_awA;
	logic [31:0] wD, next_wD;
	logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata, next_wrAddr, next_wrData;
	logic        next_busReq, next_wrValid, next_adcStart, next_irq;
	logic        dmaMode, push, trig, tick1, tick2, baseTick, halfSet;
	logic [26:0] newRemain;
	logic [3:0]  rNext;

	assign dmaMode = isDmaMode(mode);
	assign rNext   = rPtr + 4'h1;
	assign push    = adcDone && adcBusy && (fCnt != 5'h10);

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		next_mode = mode; next_autoScan = autoScan; next_contMode = contMode;
		next_running = running; next_startChan = startChan; next_adcChan = adcChan;
		next_div1 = div1; next_div2 = div2; next_cnt1 = cnt1; next_cnt2 = cnt2;
		next_dstAddr = dstAddr; next_curAddr = curAddr; next_xferCnt = xferCnt;
		next_byteCount = byteCount; next_remain = remain; next_convBytes = convBytes;
		next_stat = stat; next_mask = mask; next_baseCnt = baseCnt; next_ovrCnt = ovrCnt;
		next_halfPend = halfPend; next_adcBusy = adcBusy;
		next_wPtr = wPtr; next_rPtr = rPtr; next_fCnt = fCnt; next_busSt = busSt;
		next_awHeld = awHeld; next_wHeld = wHeld; next_awA = awA; next_wD = wD;
		next_bvalid = bvalid; next_bresp = bresp; next_rvalid = rvalid;
		next_rresp = rresp; next_rdata = rdata;
		next_busReq = busReq; next_wrValid = wrValid; next_wrAddr = wrAddr;
		next_wrData = wrData; newRemain = remain - 27'h4; halfSet = 1'b0;

		// pacer: 2 MHz base enable, then two cascaded dividers; zero stops it
		baseTick = running && (baseCnt == 3'(`ADM_BASE_DIV - 1));
		tick1 = baseTick && (div1 != 16'h0) && (cnt1 == div1 - 16'h1);
		tick2 = tick1 && (div2 != 16'h0) && (cnt2 == div2 - 16'h1);
		if (running) begin
			next_baseCnt = baseTick ? 3'h0 : baseCnt + 3'h1;
			if (baseTick) next_cnt1 = tick1 ? 16'h0 : cnt1 + 16'h1;
			if (tick1) next_cnt2 = tick2 ? 16'h0 : cnt2 + 16'h1;
		end else begin
			next_baseCnt = 3'h0;
			next_cnt1 = 16'h0;
			next_cnt2 = 16'h0;
		end

		// conversion start; block mode stops issuing once count is covered
		trig = running && !adcBusy && (fCnt < 5'h0F)
			&& (contMode || (convBytes < byteCount))
			&& (isTmrMode(mode) ? tick2 : (mode >= `ADM_MODE_EXT_POL && extTrig));
		next_adcStart = trig;
		if (trig) begin
			next_adcBusy = 1'b1;
			next_convBytes = convBytes + 27'h2;
		end
		if (adcDone) begin
			next_adcBusy = 1'b0;
			// channel advances only after the result is tagged
			if (autoScan) next_adcChan = (adcChan == 4'h0) ? startChan : adcChan - 4'h1;
			else next_adcChan = startChan;
		end
		if (push) begin
			next_wPtr = wPtr + 4'h1;
			next_fCnt = next_fCnt + 5'h1;
		end
		if (arvalid && arready && araddr == `ADM_REG_STAT) next_stat = 3'h0;

		// bus-master sequencer
		case (busSt)
			adm_pkg::BUS_IDLE: begin
				if (running && dmaMode && remain != 27'h0 && fCnt >= 5'h2) begin
					next_busReq = 1'b1;
					next_busSt = adm_pkg::BUS_REQ;
				end
			end
			adm_pkg::BUS_REQ: begin
				if (busGnt) begin
					next_wrValid = 1'b1;
					next_wrAddr = curAddr;
					next_wrData = {mem[rNext], mem[rPtr]};
					next_busSt = adm_pkg::BUS_XFER;
				end
			end
			adm_pkg::BUS_XFER: begin
				if (wrReady) begin
					next_rPtr = rPtr + 4'h2;
					next_fCnt = next_fCnt - 5'h2;
					next_xferCnt = xferCnt + 32'h2;
					next_remain = newRemain;
					next_curAddr = curAddr + 32'h4;
					halfSet = contMode && (newRemain == (byteCount >> 1) || newRemain == 27'h0);
					if (newRemain == 27'h0) begin
						if (contMode) begin
							next_remain = byteCount;
							next_curAddr = dstAddr;
						end else begin
							next_stat[`ADM_ST_DONE] = 1'b1;
							next_running = 1'b0;
						end
					end
					if ((contMode || newRemain != 27'h0) && fCnt >= 5'h4 && running) begin
						next_wrAddr = next_curAddr;
						next_wrData = {mem[rPtr + 4'h3], mem[rPtr + 4'h2]};
					end else begin
						next_wrValid = 1'b0;
						next_busReq = 1'b0;
						next_busSt = adm_pkg::BUS_IDLE;
					end
				end
			end
			default: next_busSt = adm_pkg::BUS_IDLE;
		endcase

		// AXI4-Lite write: address and data taken in either order
		if (awvalid && awready) begin
			next_awHeld = 1'b1;
			next_awA = awaddr;
		end
		if (wvalid && wready) begin
			next_wHeld = 1'b1;
			next_wD = wdata;
		end
		if (bvalid && bready) next_bvalid = 1'b0;
		if (awHeld && wHeld && !bvalid) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = 2'b00;
			case (awA)
				`ADM_REG_CTRL: begin
					next_mode = wD[2:0];
					next_autoScan = wD[`ADM_CTRL_SCAN];
					next_contMode = wD[`ADM_CTRL_CONT];
					if (wD[`ADM_CTRL_DRAIN]) next_halfPend = 1'b0;
					if (wD[`ADM_CTRL_START]) begin
						next_running = 1'b1;
						next_remain = byteCount;
						next_curAddr = dstAddr;
						next_convBytes = 27'h0;
						next_xferCnt = 32'h0;
						next_adcChan = startChan;
						next_halfPend = 1'b0;
					end
					if (wD[`ADM_CTRL_STOP]) next_running = 1'b0;
				end
				`ADM_REG_CHAN:  next_startChan = wD[3:0];
				`ADM_REG_DIV1:  next_div1 = wD[15:0];
				`ADM_REG_DIV2:  next_div2 = wD[15:0];
				`ADM_REG_ADDR:  next_dstAddr = wD;
				`ADM_REG_COUNT: next_byteCount = wD[26:0];
				`ADM_REG_MASK:  next_mask = wD[2:0];
				default:        next_bresp = 2'b10;
			endcase
		end
		// half filled at midpoint and wrap; set outranks a same-cycle drain or start
		if (halfSet) begin
			next_stat[`ADM_ST_HALF] = 1'b1;
			next_halfPend = 1'b1;
			if (halfPend) next_ovrCnt = ovrCnt + 16'h1;
			if (halfPend) next_stat[`ADM_ST_OVR] = 1'b1;
		end

		// AXI4-Lite read; status clears on read, a same-cycle event survives
		if (rvalid && rready) next_rvalid = 1'b0;
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp = 2'b00;
			next_rdata = 32'h0;
			case (araddr)
				`ADM_REG_CTRL:   next_rdata = {24'h0, 1'b0, contMode, running, 1'b0, autoScan, mode};
				`ADM_REG_CHAN:   next_rdata = {28'h0, startChan};
				`ADM_REG_DIV1:   next_rdata = {16'h0, div1};
				`ADM_REG_DIV2:   next_rdata = {16'h0, div2};
				`ADM_REG_ADDR:   next_rdata = dstAddr;
				`ADM_REG_COUNT:  next_rdata = {5'h0, byteCount};
				`ADM_REG_REMAIN: next_rdata = {5'h0, remain};
				`ADM_REG_XFER:   next_rdata = xferCnt;
				`ADM_REG_STAT:   next_rdata = {29'h0, stat};
				`ADM_REG_MASK:   next_rdata = {29'h0, mask};
				`ADM_REG_OVR:    next_rdata = {16'h0, ovrCnt};
				default:         next_rresp = 2'b10;
			endcase
		end
		next_awready = !next_awHeld && !next_bvalid;
		next_wready = !next_wHeld && !next_bvalid;
		next_arready = !next_rvalid;
		next_irq = |(next_stat & mask);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			mode <= 3'h0; autoScan <= 1'b0; contMode <= 1'b0; running <= 1'b0;
			startChan <= 4'h0; adcChan <= 4'h0; div1 <= 16'h0; div2 <= 16'h0;
			cnt1 <= 16'h0; cnt2 <= 16'h0; dstAddr <= 32'h0; curAddr <= 32'h0;
			xferCnt <= 32'h0; byteCount <= 27'h0; remain <= 27'h0; convBytes <= 27'h0;
			stat <= 3'h0; mask <= 3'h0; baseCnt <= 3'h0; ovrCnt <= 16'h0;
			halfPend <= 1'b0; adcBusy <= 1'b0; wPtr <= 4'h0; rPtr <= 4'h0; fCnt <= 5'h0;
			busSt <= adm_pkg::BUS_IDLE; awHeld <= 1'b0; wHeld <= 1'b0;
			awA <= 8'h0; wD <= 32'h0; awready <= 1'b0; wready <= 1'b0;
			bvalid <= 1'b0; bresp <= 2'b00; arready <= 1'b0; rvalid <= 1'b0;
			rresp <= 2'b00; rdata <= 32'h0; busReq <= 1'b0; wrValid <= 1'b0;
			wrAddr <= 32'h0; wrData <= 32'h0; adcStart <= 1'b0; irq <= 1'b0;
		end else begin
			mode <= next_mode; autoScan <= next_autoScan; contMode <= next_contMode;
			running <= next_running; startChan <= next_startChan; adcChan <= next_adcChan;
			div1 <= next_div1; div2 <= next_div2; cnt1 <= next_cnt1; cnt2 <= next_cnt2;
			dstAddr <= next_dstAddr; curAddr <= next_curAddr; xferCnt <= next_xferCnt;
			byteCount <= next_byteCount; remain <= next_remain; convBytes <= next_convBytes;
			stat <= next_stat; mask <= next_mask; baseCnt <= next_baseCnt;
			ovrCnt <= next_ovrCnt; halfPend <= next_halfPend; adcBusy <= next_adcBusy;
			wPtr <= next_wPtr; rPtr <= next_rPtr; fCnt <= next_fCnt; busSt <= next_busSt;
			awHeld <= next_awHeld; wHeld <= next_wHeld; awA <= next_awA; wD <= next_wD;
			awready <= next_awready; wready <= next_wready; bvalid <= next_bvalid;
			bresp <= next_bresp; arready <= next_arready; rvalid <= next_rvalid;
			rresp <= next_rresp; rdata <= next_rdata; busReq <= next_busReq;
			wrValid <= next_wrValid; wrAddr <= next_wrAddr; wrData <= next_wrData;
			adcStart <= next_adcStart; irq <= next_irq;
			if (push) mem[wPtr] <= {adcData, adcChan};
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_req_mode: assert property ($rose(busReq) |-> $past(dmaMode))
		else $error("bus requested outside transfer mode");
	a_word_step: assert property (wrValid && wrReady && !contMode && remain > 27'h4
		|=> remain == $past(remain) - 27'h4)
		else $error("remaining count did not drop by four");
	a_fifo_push: assert property (push |=> fCnt != 5'h0)
		else $error("sample not queued");
	a_bus_release: assert property (busSt == adm_pkg::BUS_XFER && wrReady && fCnt < 5'h4
		|=> !busReq && !wrValid)
		else $error("bus kept while fifo short");
	a_resume_req: assert property (busSt == adm_pkg::BUS_IDLE && running && dmaMode
		&& remain != 27'h0 && fCnt >= 5'h2 |=> busReq)
		else $error("transfer not resumed");
	a_done_flag: assert property (wrValid && wrReady && !contMode && remain == 27'h4
		|=> stat[`ADM_ST_DONE] && !running ##1 irq == mask[`ADM_ST_DONE])
		else $error("completion not flagged");
	a_scan_wrap: assert property (adcDone && autoScan && adcChan == 4'h0
		|=> adcChan == $past(startChan))
		else $error("scan did not reload");
	a_stop_halt: assert property (!running |=> !adcStart && cnt1 == 16'h0)
		else $error("pacer runs while stopped");
	c_block_done: cover property ($rose(stat[`ADM_ST_DONE]));
	c_half_fill: cover property ($rose(stat[`ADM_ST_HALF]));
	c_overrun: cover property (ovrCnt != 16'h0);
endmodule
`default_nettype wire

// *** test/adm_far_model.sv ***
// far-side model of the sampling bus master: arbiter, host memory and converter
`timescale 1ns/1ps
`default_nettype none
module adm_far_model (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        slow,
	input  wire logic        busReq,
	output logic             busGnt,
	input  wire logic        wrValid,
	input  wire logic [31:0] wrAddr,
	input  wire logic [31:0] wrData,
	output logic             wrReady,
	input  wire logic        adcStart,
	input  wire logic [3:0]  adcChan,
	output logic             adcDone,
	output logic [11:0]      adcData
);
	logic [31:0] memAddr[$];
	logic [31:0] memData[$];
	logic [3:0]  chanLog[$];
	int          grants, starts, gap, since, conv, busy, reqAge;
	// ----------------------------------------
	// arbiter and memory
	// ----------------------------------------
	// grant waits two cycles so the block must hold its request; slow memory stalls
	always @(posedge core_clk) begin
		if (!rst_b) begin
			busGnt <= 1'h0;
			wrReady <= 1'h0;
			reqAge = 0;
		end else begin
			wrReady <= slow ? ~wrReady : 1'h1;
			if (!busReq) begin
				busGnt <= 1'h0;
				reqAge = 0;
			end else begin
				reqAge++;
				if (reqAge == 2 && !busGnt) begin
					busGnt <= 1'h1;
					grants++;
				end
			end
			if (wrValid && wrReady) begin
				memAddr.push_back(wrAddr);
				memData.push_back(wrData);
			end
		end
	end
	// ----------------------------------------
	// converter
	// ----------------------------------------
	// result idles on a toggling pattern so a stale sample never looks valid
	always @(posedge core_clk) begin
		adcDone <= 1'h0;
		adcData <= ~adcData;
		if (!rst_b) begin
			adcData <= 12'h000;
			busy = 0;
		end else begin
			since++;
			if (busy > 0) begin
				busy--;
				if (busy == 0) begin
					adcDone <= 1'h1;
					adcData <= 12'hA00 + conv[11:0];
					conv++;
				end
			end
			if (adcStart) begin
				chanLog.push_back(adcChan);
				starts++;
				gap = since;
				since = 0;
				busy = 4;
			end
		end
	end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench of the sampling bus master
`timescale 1ns/1ps
`default_nettype none
`include "adm_cfg.svh"
module tb_top;
	logic        core_clk = 1'h0;
	logic        rst_b = 1'h0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        extTrig = 1'h0, extOn = 1'h0, slow = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, busReq, busGnt, wrValid, wrReady;
	logic        adcStart, adcDone, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, wrAddr, wrData, rd;
	logic [3:0]  adcChan;
	logic [11:0] adcData;
	int          numErrors = 0, nTests = 0, cyc = 0, k0, n;

	always #50 core_clk = ~core_clk;
	// external trigger pulses every 20 cycles while enabled
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		extTrig <= extOn && (cyc % 20 == 0);
	end

	adm_dma u_dut (.core_clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .busReq, .busGnt, .wrValid, .wrAddr, .wrData, .wrReady,
		.adcStart, .adcChan, .adcDone, .adcData, .extTrig, .irq);
	adm_far_model u_far (.core_clk, .rst_b, .slow, .busReq, .busGnt, .wrValid, .wrAddr,
		.wrData, .wrReady, .adcStart, .adcChan, .adcDone, .adcData);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
			numErrors++;
		end
	endtask
	// address and data offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (!rvalid);
		rd = rdata;
		rready <= 1'h0;
	endtask
	task automatic waitW(input int w);
		n = 0;
		while (u_far.memData.size() < w && n < 5000) begin
			@(posedge core_clk);
			n++;
		end
	endtask
	// sample k of a scan from channel 3: result above the channel number
	function automatic logic [15:0] smp(input int k);
		return {12'hA00 + k[11:0], 4'(3 - k % 4)};
	endfunction
	task automatic endOfTest;
		if (numErrors == 0 && nTests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge core_clk);
		rst_b <= 1'h1;
		// reset values, then an unmapped offset both ways
		axr(`ADM_REG_STAT);
		chk("stat", rd, 32'h0);
		axr(8'h2C);
		chk("rresp", {30'h0, rresp}, 32'h2);
		axw(8'h2C, 32'h1);
		chk("bresp", {30'h0, bresp}, 32'h2);
		// timer-paced block of four longwords scanning down from channel 3, slow memory
		axw(`ADM_REG_CHAN, 32'h3);
		axw(`ADM_REG_DIV1, 32'h2);
		axw(`ADM_REG_DIV2, 32'h3);
		axw(`ADM_REG_ADDR, 32'h1000);
		axw(`ADM_REG_COUNT, 32'h10);
		axw(`ADM_REG_MASK, 32'h1);
		k0 = u_far.conv;
		slow <= 1'h1;
		axw(`ADM_REG_CTRL, 32'h1A);
		waitW(4);
		repeat (10) @(posedge core_clk);
		chk("writes", u_far.memData.size(), 4);
		for (int i = 0; i < 4; i++) begin
			chk("addr", u_far.memAddr[i], 32'h1000 + 4 * i);
			chk("data", u_far.memData[i], {smp(k0 + 2 * i + 1), smp(k0 + 2 * i)});
		end
		chk("gap", u_far.gap, 30);
		chk("grants", u_far.grants, 4);
		chk("irq", irq, 1);
		axr(`ADM_REG_REMAIN);
		chk("remain", rd, 0);
		axr(`ADM_REG_XFER);
		chk("xfer", rd, 8);
		axr(`ADM_REG_STAT);
		chk("done", rd, 1);
		axr(`ADM_REG_STAT);
		chk("stat clear", rd, 0);
		chk("irq clear", irq, 0);
		chk("starts", u_far.starts, 8);
		// interrupt-transfer mode on channel 5 converts but never asks for the bus
		axw(`ADM_REG_CHAN, 32'h5);
		axw(`ADM_REG_CTRL, 32'h11);
		repeat (200) @(posedge core_clk);
		axw(`ADM_REG_CTRL, 32'h21);
		chk("grants", u_far.grants, 4);
		chk("chan", u_far.chanLog[$], 5);
		// external-trigger interrupt mode converts, still without a bus request
		k0 = u_far.starts;
		extOn <= 1'h1;
		axw(`ADM_REG_CTRL, 32'h14);
		repeat (100) @(posedge core_clk);
		axw(`ADM_REG_CTRL, 32'h24);
		extOn <= 1'h0;
		chk("ext starts", {31'h0, u_far.starts > k0}, 32'h1);
		chk("grants", u_far.grants, 4);
		// stop in mid-block: triggers halt, counts stay readable
		axw(`ADM_REG_COUNT, 32'h40);
		axw(`ADM_REG_CTRL, 32'h12);
		waitW(6);
		axw(`ADM_REG_CTRL, 32'h22);
		repeat (20) @(posedge core_clk);
		k0 = u_far.starts;
		repeat (300) @(posedge core_clk);
		chk("starts", u_far.starts, k0);
		axr(`ADM_REG_XFER);
		chk("xfer", rd, 2 * (u_far.memData.size() - 4));
		axr(`ADM_REG_REMAIN);
		chk("remain", rd, 64 - 4 * (u_far.memData.size() - 4));
		chk("chan", u_far.memData[4][3:0], 5);
		// a zero divider keeps the pacer silent
		axw(`ADM_REG_DIV1, 32'h0);
		k0 = u_far.starts;
		axw(`ADM_REG_CTRL, 32'h12);
		repeat (300) @(posedge core_clk);
		chk("starts", u_far.starts, k0);
		axw(`ADM_REG_CTRL, 32'h22);
		// continuous, externally triggered, halves never drained
		axw(`ADM_REG_COUNT, 32'h10);
		axw(`ADM_REG_ADDR, 32'h2000);
		axw(`ADM_REG_MASK, 32'h6);
		k0 = u_far.memData.size();
		extOn <= 1'h1;
		axw(`ADM_REG_CTRL, 32'h55);
		waitW(k0 + 5);
		chk("wrap", u_far.memAddr[k0 + 4], 32'h2000);
		chk("irq", irq, 1);
		axr(`ADM_REG_STAT);
		chk("half", rd & 32'h2, 32'h2);
		waitW(k0 + 10);
		axr(`ADM_REG_OVR);
		chk("overruns", {31'h0, rd != 32'h0}, 32'h1);
		axr(`ADM_REG_STAT);
		chk("overrun", rd & 32'h4, 32'h4);
		axw(`ADM_REG_CTRL, 32'h25);
		extOn <= 1'h0;
		endOfTest;
	end

	// watchdog: the scenarios need a few thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		numErrors++;
		endOfTest;
	end
endmodule
`default_nettype wire
